// [hdl/drb_pkg.sv]
// Constants, types and helpers of the readback and status block.
// Assumes one 50 MHz system clock; all users reference by drb_pkg::name.
package drb_pkg;

  // ----------------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------------
  localparam int          CMD_BITS      = 24;
  localparam logic [4:0]  CMD_BIT_COUNT = 5'h18;
  localparam int          CMD_RW_BIT    = 23;
  localparam int          CMD_ADDR_HI   = 22;
  localparam int          CMD_ADDR_LO   = 21;
  localparam int          CMD_SEL_MSB   = 20;
  localparam int          CMD_SEL_LSB   = 16;
  localparam int          RET_DATA_BITS = 16;
  localparam logic [7:0]  RET_TOP_FILL  = 8'h00;

  // ----------------------------------------------------------------------
  // Register selector values
  // ----------------------------------------------------------------------
  localparam logic [4:0]  SEL_DATA_A     = 5'h00;
  localparam logic [4:0]  SEL_CTRL_A     = 5'h04;
  localparam logic [4:0]  SEL_GAIN_A     = 5'h08;
  localparam logic [4:0]  SEL_OFFSET_A   = 5'h0C;
  localparam logic [4:0]  SEL_CLRCODE_A  = 5'h10;
  localparam logic [4:0]  SEL_SLEW_A     = 5'h14;
  localparam logic [4:0]  SEL_STATUS     = 5'h18;
  localparam logic [4:0]  SEL_MAIN_CTRL  = 5'h19;
  localparam logic [4:0]  SEL_BOOST_CTRL = 5'h1A;
  localparam int          NUM_REGS       = 27;

  // ----------------------------------------------------------------------
  // Status register fields and reset values
  // ----------------------------------------------------------------------
  localparam int          ST_BOOST_LSB  = 12;
  localparam int          ST_TOGGLE     = 11;
  localparam int          ST_CHECKSUM   = 10;
  localparam int          ST_RAMP       = 9;
  localparam int          ST_OVERTEMP   = 8;
  localparam int          ST_FAULT_LSB  = 0;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam int          MAIN_SOW_BIT  = 12;

  // ----------------------------------------------------------------------
  // Link state machine, Gray coded along the path
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LNK_IDLE   = 2'b00,
    LNK_SHIFT  = 2'b01,
    LNK_DECODE = 2'b11,
    LNK_FETCH  = 2'b10
  } drb_state_t;

  // Selector held in the register store (0-23, main and boost control; not status or 27-31)
  function automatic logic drb_in_store(input logic [4:0] sel);
    return (sel < SEL_STATUS) || (sel == SEL_MAIN_CTRL) ||
           (sel == SEL_BOOST_CTRL);
  endfunction : drb_in_store

endpackage : drb_pkg

// [hdl/drb_regstore.sv]
// Small register store for the per-channel and global readable words.
// Assumes a single clock; read data appear one cycle after rd_en_i.
`timescale 1ns/1ps
module drb_regstore #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 27,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Write port
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input  wire logic             rd_en_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Cleared on reset so a read before any write returns a known word
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= WIDTH'(drb_pkg::REG_RESET);
      end
    end else if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read; out-of-range addresses return zero
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rd_data_reg <= '0;
    end else if (rd_en_i) begin
      if (int'(rd_addr_i) < DEPTH) begin
        rd_data_reg <= mem_reg[rd_addr_i];
      end else begin
        rd_data_reg <= '0;
      end
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule : drb_regstore

// [hdl/drb_readback.sv]
// Readback decoder and fault status register of a quad current converter.
// Assumes link pins and analog monitors are asynchronous to clk_i and
// that the write path, same clock, delivers decoded register writes.
//
// How it works
// [R1] 24-bit command: read flag, address, selector
// [R2] Selectors 0-3 return channel data words
// [R3] Selectors 4-7 return channel control words
// [R4] Selectors 8-11 return channel gain trims
// [R5] Selectors 12-15 return channel offset trims
// [R6] Selectors 16-19 return channel clear codes
// [R7] Selectors 20-23 return channel slew controls
// [R8] 24 status, 25 main, 26 boost control
// [R9] Status register cannot be written over link
// [R10] Status-on-write mode shifts status every transfer
// [R11] Otherwise status only through normal readback
// [R12] Compliance flags D15-D12 also force fault bits
// [R13] D10 flags last word failed checksum
// [R14] D9 high while any channel ramps
// [R15] D8 set on core overtemperature
// [R16] D3-D0 channel output faults; D7-D4 zero
// [R17] User toggle bit readable in status
// [R18] Next transfer returns 8 fill, 16 data
// [R19] Serial output changes on rising clock
// [R20] Act only on commands matching address pins
`timescale 1ns/1ps
module drb_readback #(
  parameter int NREG = drb_pkg::NUM_REGS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Serial link pins
  input  wire logic        sclk_i,
  input  wire logic        sync_n_i,
  input  wire logic        sdin_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  // Device address pins
  input  wire logic        device_addr_hi_i,
  input  wire logic        device_addr_lo_i,
  // Analog monitors, bit 0 is channel A
  input  wire logic [3:0]  boost_compliance_i,
  input  wire logic [3:0]  output_fault_i,
  input  wire logic        overtemp_i,
  // Same-clock inputs from neighbouring logic
  input  wire logic        ramp_active_i,
  input  wire logic        checksum_fail_i,
  input  wire logic        user_toggle_i,
  input  wire logic        wr_en_i,
  input  wire logic [4:0]  wr_sel_i,
  input  wire logic [15:0] wr_data_i,
  // Observation
  output logic [15:0]      fault_status_o,
  output logic             status_on_write_en_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int NPIN = 14;

  logic [NPIN-1:0]     pin_meta_reg;
  logic [NPIN-1:0]     pin_sync_reg;
  logic                sclk_dly_reg;
  logic                sync_dly_reg;
  drb_pkg::drb_state_t state_reg;
  drb_pkg::drb_state_t state_next;
  logic [23:0]         rx_reg;
  logic [23:0]         tx_reg;
  logic [4:0]          bit_cnt_reg;
  logic                sdo_reg;
  logic                sdo_oe_reg;
  logic                tx_valid_reg;
  logic                tx_is_status_reg;
  logic                pend_valid_reg;
  logic                pend_is_status_reg;
  logic                pend_in_store_reg;
  logic [15:0]         pend_word_reg;
  logic [15:0]         status_reg;
  logic                checksum_reg;
  logic                sow_reg;
  logic [15:0]         store_rdata;
  logic [15:0]         load_word;
  logic                load_is_status;

  logic       sclk_s;
  logic       sync_n_s;
  logic       sdin_s;
  logic [1:0] addr_s;
  logic [3:0] comp_s;
  logic [3:0] fault_s;
  logic       otemp_s;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       frame_start;
  logic       frame_end;
  logic       cmd_full;
  logic [4:0] cmd_sel;
  logic       read_hit;
  logic       store_rd_en;
  logic       store_wr_en;
  logic       status_taken;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Every pin passes two flops; only the second stage is used below.
  // Frame select resets to its idle high level, so no false frame.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pin_meta_reg    <= '0;
      pin_meta_reg[1] <= 1'b1;
      pin_sync_reg    <= '0;
      pin_sync_reg[1] <= 1'b1;
    end else begin
      pin_meta_reg <= {overtemp_i, output_fault_i, boost_compliance_i,
                       device_addr_hi_i, device_addr_lo_i,
                       sdin_i, sync_n_i, sclk_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign sclk_s   = pin_sync_reg[0];
  assign sync_n_s = pin_sync_reg[1];
  assign sdin_s   = pin_sync_reg[2];
  assign addr_s   = pin_sync_reg[4:3];
  assign comp_s   = pin_sync_reg[8:5];
  assign fault_s  = pin_sync_reg[12:9];
  assign otemp_s  = pin_sync_reg[13];

  // Edge finders; sync starts high so reset does not fake a frame
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sclk_dly_reg <= 1'b0;
      sync_dly_reg <= 1'b1;
    end else begin
      sclk_dly_reg <= sclk_s;
      sync_dly_reg <= sync_n_s;
    end
  end

  assign sclk_rise   = sclk_s & ~sclk_dly_reg;
  assign sclk_fall   = ~sclk_s & sclk_dly_reg;
  assign frame_start = ~sync_n_s & sync_dly_reg;
  assign frame_end   = sync_n_s & ~sync_dly_reg;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Longer frames (checksum appended) are not taken as read commands
  assign cmd_full = (bit_cnt_reg == drb_pkg::CMD_BIT_COUNT); // see [R1]
  assign cmd_sel  = rx_reg[drb_pkg::CMD_SEL_MSB:drb_pkg::CMD_SEL_LSB];
  // Foreign device address means the command is ignored
  assign read_hit = cmd_full && rx_reg[drb_pkg::CMD_RW_BIT] &&
                    (rx_reg[drb_pkg::CMD_ADDR_HI] == addr_s[1]) &&
                    (rx_reg[drb_pkg::CMD_ADDR_LO] == addr_s[0]); // see [R20]

  // Selector addresses the store directly: channel groups of four
  // sit at 0, 4, 8, 12, 16 and 20, global words at 25 and 26
  assign store_rd_en = (state_reg == drb_pkg::LNK_DECODE) && read_hit &&
                       drb_pkg::drb_in_store(cmd_sel); // see [R2] see [R3]

  // Status slot is never written over the link
  assign store_wr_en = wr_en_i &&
                       drb_pkg::drb_in_store(wr_sel_i); // see [R9]

  drb_regstore #(
    .WIDTH (16),
    .DEPTH (NREG),
    .AW    (5)
  ) u_store (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .wr_en_i   (store_wr_en),
    .wr_addr_i (wr_sel_i),
    .wr_data_i (wr_data_i),
    .rd_en_i   (store_rd_en),
    .rd_addr_i (cmd_sel),                    // see [R4] see [R5] see [R6]
    .rd_data_o (store_rdata)                 // see [R7]
  );

  // ----------------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------------
  // Next state; a frame needs sync high for at least three clocks
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      drb_pkg::LNK_IDLE: begin
        if (frame_start) begin
          state_next = drb_pkg::LNK_SHIFT;
        end
      end
      drb_pkg::LNK_SHIFT: begin
        if (frame_end) begin
          state_next = drb_pkg::LNK_DECODE;
        end
      end
      drb_pkg::LNK_DECODE: begin
        if (read_hit) begin
          state_next = drb_pkg::LNK_FETCH;
        end else begin
          state_next = drb_pkg::LNK_IDLE;
        end
      end
      drb_pkg::LNK_FETCH: begin
        state_next = drb_pkg::LNK_IDLE;
      end
      default: begin
        state_next = drb_pkg::LNK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= drb_pkg::LNK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  // Input sampled on falling clock; counter saturates at 31
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_reg      <= '0;
      bit_cnt_reg <= '0;
    end else if (state_reg == drb_pkg::LNK_IDLE && frame_start) begin
      bit_cnt_reg <= '0;
    end else if (state_reg == drb_pkg::LNK_SHIFT && sclk_fall) begin
      rx_reg <= {rx_reg[22:0], sdin_s};
      if (bit_cnt_reg != 5'h1F) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pending readback word
  // ----------------------------------------------------------------------
  // Status-on-write mode hides other registers, so readback is status
  always_comb begin
    load_is_status = sow_reg || !pend_valid_reg ||
                     pend_is_status_reg;                  // see [R10]
    load_word      = load_is_status ? status_reg : pend_word_reg;
  end

  // Armed by a matching read, consumed by the following frame
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pend_valid_reg     <= 1'b0;
      pend_is_status_reg <= 1'b0;
      pend_in_store_reg  <= 1'b0;
      pend_word_reg      <= '0;
    end else if (state_reg == drb_pkg::LNK_DECODE && read_hit) begin
      pend_is_status_reg <= (cmd_sel == drb_pkg::SEL_STATUS); // see [R8]
      pend_in_store_reg  <= drb_pkg::drb_in_store(cmd_sel);
    end else if (state_reg == drb_pkg::LNK_FETCH) begin
      pend_valid_reg <= 1'b1;
      // Unmapped selectors return zero
      pend_word_reg  <= pend_in_store_reg ? store_rdata : 16'h0000;
    end else if (state_reg == drb_pkg::LNK_SHIFT && frame_end) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  // Word loaded at frame start; top byte is filler
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_reg           <= '0;
      tx_valid_reg     <= 1'b0;
      tx_is_status_reg <= 1'b0;
    end else if (state_reg == drb_pkg::LNK_IDLE && frame_start) begin
      tx_reg           <= {drb_pkg::RET_TOP_FILL, load_word}; // see [R18]
      // Without the mode, status only leaves through a readback
      tx_valid_reg     <= pend_valid_reg || sow_reg;          // see [R11]
      tx_is_status_reg <= load_is_status;
    end else if (state_reg == drb_pkg::LNK_SHIFT && sclk_rise) begin
      tx_reg <= {tx_reg[22:0], 1'b0};
    end else if (state_reg != drb_pkg::LNK_SHIFT) begin
      tx_valid_reg <= 1'b0;
    end
  end

  // Output bit moves on each rising edge so host samples on falling
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else if (state_reg == drb_pkg::LNK_SHIFT) begin
      sdo_oe_reg <= tx_valid_reg && !frame_end;
      if (sclk_rise) begin
        sdo_reg <= tx_reg[23];                              // see [R19]
      end
    end else begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end
  end

  assign sdo_o    = sdo_reg;
  assign sdo_oe_o = sdo_oe_reg;

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  // A full frame that carried the status word counts as a status read
  assign status_taken = (state_reg == drb_pkg::LNK_SHIFT) && frame_end &&
                        tx_valid_reg && tx_is_status_reg &&
                        (bit_cnt_reg >= drb_pkg::CMD_BIT_COUNT);

  // Sticky checksum flag; a new failure wins over the read clear
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      checksum_reg <= 1'b0;
    end else if (checksum_fail_i) begin
      checksum_reg <= 1'b1;                                 // see [R13]
    end else if (status_taken) begin
      checksum_reg <= 1'b0;
    end
  end

  // Live flags registered once; compliance loss also marks the fault
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      status_reg <= drb_pkg::STATUS_RESET;
    end else begin
      status_reg <= '0;                                     // see [R16]
      status_reg[drb_pkg::ST_BOOST_LSB +: 4] <= comp_s;     // see [R12]
      status_reg[drb_pkg::ST_FAULT_LSB +: 4] <= fault_s | comp_s;
      status_reg[drb_pkg::ST_TOGGLE]   <= user_toggle_i;    // see [R17]
      status_reg[drb_pkg::ST_CHECKSUM] <= checksum_reg;
      status_reg[drb_pkg::ST_RAMP]     <= ramp_active_i;    // see [R14]
      status_reg[drb_pkg::ST_OVERTEMP] <= otemp_s;          // see [R15]
    end
  end

  assign fault_status_o = status_reg;

  // Mode bit shadowed from main control writes; off after reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sow_reg <= 1'b0;
    end else if (wr_en_i && wr_sel_i == drb_pkg::SEL_MAIN_CTRL) begin
      sow_reg <= wr_data_i[drb_pkg::MAIN_SOW_BIT];          // see [R10]
    end
  end

  assign status_on_write_en_o = sow_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_read_hit;
    state_reg == drb_pkg::LNK_DECODE && read_hit;
  endsequence

  sequence seq_sow_start;
    state_reg == drb_pkg::LNK_IDLE && frame_start && sow_reg;
  endsequence

  chk_read_arms: assert property ( // see [R1]
    seq_read_hit |=> state_reg == drb_pkg::LNK_FETCH ##1 pend_valid_reg)
    else $error("matching read did not arm a readback");

  chk_addr_ignore: assert property ( // see [R20]
    state_reg == drb_pkg::LNK_DECODE && !read_hit
    |=> state_reg == drb_pkg::LNK_IDLE && !pend_valid_reg ##1 !pend_valid_reg)
    else $error("command for another address was acted on");

  chk_store_word: assert property ( // see [R2]
    seq_read_hit ##1 pend_in_store_reg |=> pend_word_reg == store_rdata)
    else $error("readback word differs from selected register");

  chk_status_ro: assert property ( // see [R9]
    wr_en_i && wr_sel_i == drb_pkg::SEL_STATUS |-> !store_wr_en)
    else $error("status slot written over the link");

  chk_sow_load: assert property ( // see [R10]
    seq_sow_start |=> tx_reg[15:0] == $past(status_reg) && tx_valid_reg)
    else $error("status not loaded for a write transfer");

  chk_boost_fault: assert property ( // see [R12]
    (status_reg[15:12] & ~status_reg[3:0]) == 4'h0)
    else $error("compliance flag without matching fault bit");

  chk_cksum_set: assert property ( // see [R13]
    checksum_fail_i |=> ##1 status_reg[drb_pkg::ST_CHECKSUM])
    else $error("checksum failure not reported");

  chk_ramp_follow: assert property ( // see [R14]
    ramp_active_i |=> status_reg[drb_pkg::ST_RAMP])
    else $error("ramp flag missing while ramping");

  chk_top_fill: assert property ( // see [R18]
    state_reg == drb_pkg::LNK_IDLE && frame_start
    |=> tx_reg[23:16] == drb_pkg::RET_TOP_FILL)
    else $error("top byte of returned word not filler");

  chk_sdo_rise: assert property ( // see [R19]
    state_reg == drb_pkg::LNK_SHIFT && $changed(sdo_reg) |-> $past(sclk_rise))
    else $error("serial output moved without rising clock");

endmodule : drb_readback

// [verification/drb_host_model.sv]
// Host side of the serial link: frames commands and collects answers.
// Assumes the 50 MHz bench clock; one serial bit spans 8 clocks (160 ns).
`timescale 1ns/1ps
module drb_host_model (
  // Clock
  input  wire logic clk_i,
  // Link pins
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      sdin_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  // ----------------------------------------------------------------
  // Idle levels: link clock stands low outside frames
  // ----------------------------------------------------------------
  initial begin
    sclk_o   = 1'b0;
    sync_n_o = 1'b1;
    sdin_o   = 1'b0;
  end

  // One frame, MSB first; the answer is taken just before the next
  // rising edge, so a slow device still has its bit settled
  task automatic xfer(input logic [23:0] cmd, input int nbits,
                      output logic [23:0] rx, output logic oe);
    rx = '0;
    oe = 1'b0;
    sync_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      sclk_o <= 1'b1;
      sdin_o <= cmd[23-i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      rx = {rx[22:0], sdo_i};
      oe = oe | sdo_oe_i;
    end
    sync_n_o <= 1'b1;
    sdin_o   <= ~sdin_o; // Released line must not keep its last value
    repeat (10) @(posedge clk_i); // Gap well above the 3-clock minimum
  endtask : xfer
endmodule : drb_host_model

// [verification/drb_readback_tb.sv]
// Self-checking bench of the readback decoder and status register.
// Assumes drb_pkg is compiled first; host model drives the link pins.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s expected %h seen %h", n, e, g); \
  end end
module drb_readback_tb;
  localparam logic [15:0] ST  = 16'h2B07;
  localparam logic [23:0] NOP = 24'h1CE000;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sclk, sync_n, sdin, sdo, sdo_oe, sdo_line, oe;
  logic [3:0]  boost = 4'h2;
  logic [1:0]  dev_addr = 2'b10;
  logic [3:0]  ofault = 4'h5;
  logic        overtemp = 1'b1;
  logic        ramp = 1'b1;
  logic        cks_fail = 1'b0;
  logic        toggle = 1'b1;
  logic        wr_en = 1'b0;
  logic [4:0]  wr_sel = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] status, cyc = 16'h0000;
  logic        sow;
  logic [23:0] rx;
  int          miscompares = 0;
  int          n_checks = 0;

  always #10 clk_i = ~clk_i;
  // Undriven line toggles so a stale bit can never pass for data
  assign sdo_line = sdo_oe ? sdo : cyc[0];

  drb_readback i_drb_readback (.clk_i(clk_i), .nrst_i(nrst_i),
    .sclk_i(sclk), .sync_n_i(sync_n), .sdin_i(sdin), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .device_addr_hi_i(dev_addr[1]),
    .device_addr_lo_i(dev_addr[0]),
    .boost_compliance_i(boost), .output_fault_i(ofault),
    .overtemp_i(overtemp), .ramp_active_i(ramp),
    .checksum_fail_i(cks_fail), .user_toggle_i(toggle), .wr_en_i(wr_en),
    .wr_sel_i(wr_sel), .wr_data_i(wr_data), .fault_status_o(status),
    .status_on_write_en_o(sow));
  drb_host_model i_drb_host_model (.clk_i(clk_i), .sclk_o(sclk),
    .sync_n_o(sync_n), .sdin_o(sdin), .sdo_i(sdo_line), .sdo_oe_i(sdo_oe));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    wr_en   <= 1'b1;
    wr_sel  <= s;
    wr_data <= d;
    @(posedge clk_i);
    wr_en <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic xf(input logic [23:0] c, input int n);
    i_drb_host_model.xfer(c, n, rx, oe);
  endtask : xf

  function automatic logic [23:0] rcmd(input logic [4:0] s);
    return {1'b1, 2'b10, s, 16'h0000};
  endfunction : rcmd

  // Expected answer of a selector; store words carry their selector
  function automatic logic [23:0] expv(input int s);
    if (s == 24) return {8'h00, ST};
    if (s > 26) return 24'h000000;
    return {8'h00, 8'hA4, 3'h0, 5'(s)};
  endfunction : expv

  // Hang guard, far above the roughly 9000 cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h7530) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] bad [3];
    int          nb [3];
    bad = '{{1'b1, 2'b01, 5'h19, 16'h0}, {1'b0, 2'b10, 5'h19, 16'h0},
            {1'b1, 2'b10, 5'h19, 16'h0}};
    nb = '{24, 24, 20};
    repeat (11) @(posedge clk_i);
    `CHK("reset status", 16'h0000, status)
    `CHK("reset oe", 1'b0, sdo_oe)
    @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("status", ST, status)
    `CHK("mode reset", 1'b0, sow)
    // Fill the store, status selector included, then read all back
    for (int s = 0; s < 27; s++) wr(5'(s), {8'hA4, 3'h0, 5'(s)});
    xf(rcmd(5'h00), 24);
    for (int s = 1; s <= 28; s++) begin
      xf((s < 28) ? rcmd(5'(s)) : NOP, 24);
      `CHK("readback", expv(s-1), rx)
      `CHK("readback oe", 1'b1, oe)
    end
    // Foreign address, write flag, short frame: no answer follows
    for (int k = 0; k < 3; k++) begin
      xf(bad[k], nb[k]);
      xf(NOP, 24);
      `CHK("refused oe", 1'b0, oe)
    end
    // Same command is taken once the pins carry its address
    dev_addr <= 2'b01;
    xf(bad[0], 24);
    xf(NOP, 24);
    `CHK("own address", expv(25), rx)
    dev_addr <= 2'b10;
    cks_fail <= 1'b1;
    @(posedge clk_i);
    cks_fail <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("checksum flag", 1'b1, status[10])
    xf(rcmd(drb_pkg::SEL_STATUS), 24);
    xf(NOP, 24);
    `CHK("status read", {8'h00, ST | 16'h0400}, rx)
    repeat (4) @(posedge clk_i);
    `CHK("checksum clear", 1'b0, status[10])
    {toggle, ramp, overtemp, boost, ofault} <= {7'h00, 4'h8};
    repeat (5) @(posedge clk_i);
    `CHK("status quiet", 16'h0008, status)
    wr(drb_pkg::SEL_MAIN_CTRL, 16'h1000);
    `CHK("mode set", 1'b1, sow)
    xf(NOP, 24);
    `CHK("status on write", 24'h000008, rx)
    `CHK("status on write oe", 1'b1, oe)
    wr(drb_pkg::SEL_MAIN_CTRL, 16'h0000);
    xf(NOP, 24);
    `CHK("mode off oe", 1'b0, oe)
    summarize();
  end
endmodule : drb_readback_tb
